// ===== verilog/susc_params.svh
`ifndef SUSC_PARAMS_SVH
`define SUSC_PARAMS_SVH

// special-function address of clock_source_select
`define SUSC_SELECT_ADDR   8'hA9
// reset value of clock_source_select
`define SUSC_SELECT_RESET  8'h00

// field positions inside clock_source_select
`define SUSC_UNUSED_HI_BIT 7
`define SUSC_USB_MSB       6
`define SUSC_USB_LSB       4
`define SUSC_UNUSED_MSB    3
`define SUSC_UNUSED_LSB    2
`define SUSC_SYS_MSB       1
`define SUSC_SYS_LSB       0

`endif

// ===== verilog/susc_pkg.sv
package susc_pkg;

   // usb_clock_source_field codes
   typedef enum logic [2:0] {
      USB_MUL      = 3'h0,
      USB_INT_DIV2 = 3'h1,
      USB_EXT      = 3'h2,
      USB_EXT_DIV2 = 3'h3,
      USB_EXT_DIV3 = 3'h4,
      USB_EXT_DIV4 = 3'h5,
      USB_RSVD_6   = 3'h6,
      USB_RSVD_7   = 3'h7
   } susc_usb_src_t;

   // system_clock_source_field codes
   typedef enum logic [1:0] {
      SYS_INT      = 2'h0,
      SYS_EXT      = 2'h1,
      SYS_MUL_DIV2 = 2'h2,
      SYS_RSVD     = 2'h3
   } susc_sys_src_t;

   // stored fields; the unused bits have no storage at all
   typedef struct packed {
      susc_usb_src_t usbSrc;
      susc_sys_src_t sysSrc;
   } susc_cfg_t;

endpackage : susc_pkg

// ===== verilog/susc_clock_select.sv
`timescale 1ns/1ns
`include "susc_params.svh"
// Overview of operation
// R1: usb bits 6:4: mul, int/2, ext, ext/2, ext/3, ext/4; 110, 111 reserved.
// R2: system bits 1:0: internal, external, multiplier/2; 11 reserved.
// R3: full speed usb needs software to set up a 48 MHz usb clock.
// R4: low speed usb needs software to set up a 6 MHz usb clock.
// R5: bit 7 is not stored, reads zero, writes ignored.
// R6: bits 3 and 2 are not stored, read zero, writes ignored.
// R7: low speed: internal divided by two with 001, or 24 MHz crystal with 101.
// R8: system clock switches on the fly only to an enabled, settled source.
// R9: reset clears the register: internal system clock, multiplier usb clock.
module susc_clock_select
   import susc_pkg::*;
(
   input  wire logic       sys_clk,
   input  wire logic       rstn,
   input  wire logic [7:0] sfrAddr,
   input  wire logic [7:0] sfrWrData,
   input  wire logic       sfrWr,
   input  wire logic       sfrRd,
   output      logic [7:0] sfrRdData,
   input  wire logic       intOscTick,
   input  wire logic       extOscTick,
   input  wire logic       mulTick,
   input  wire logic       intOscReady,
   input  wire logic       extOscReady,
   input  wire logic       mulReady,
   output      logic       sysClkTick,
   output      logic       usbClkTick,
   output      susc_sys_src_t sysSrcActive
);

   localparam logic [7:0] RESET_VAL = `SUSC_SELECT_RESET;
   localparam logic [7:0] REG_ADDR  = `SUSC_SELECT_ADDR;

   susc_cfg_t  cfg;
   logic       intPhase;
   logic       mulPhase;
   logic [1:0] extCnt;
   logic       regHit;
   logic       intHalfTick;
   logic       mulHalfTick;
   logic       extDivTick;

   // divide ratio applied to the external oscillator for usb
   function automatic logic [2:0] ext_divisor(input susc_usb_src_t s);
      unique case (s)
         USB_EXT_DIV2: ext_divisor = 3'h2;
         USB_EXT_DIV3: ext_divisor = 3'h3;
         USB_EXT_DIV4: ext_divisor = 3'h4;
         default:      ext_divisor = 3'h1;
      endcase
   endfunction : ext_divisor

   // whether a system clock source is enabled and settled
   function automatic logic src_ready(input susc_sys_src_t s,
                                      input logic intRdy,
                                      input logic extRdy,
                                      input logic mulRdy);
      unique case (s)
         SYS_INT:      src_ready = intRdy;
         SYS_EXT:      src_ready = extRdy;
         SYS_MUL_DIV2: src_ready = mulRdy;
         SYS_RSVD:     src_ready = 1'b0;
      endcase
   endfunction : src_ready

   assign regHit = (sfrAddr == REG_ADDR);

   // register write; only the two fields are stored
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         cfg.usbSrc <= susc_usb_src_t'(
                       RESET_VAL[`SUSC_USB_MSB:`SUSC_USB_LSB]); // see R9
         cfg.sysSrc <= susc_sys_src_t'(
                       RESET_VAL[`SUSC_SYS_MSB:`SUSC_SYS_LSB]); // see R9
      end else if (sfrWr && regHit) begin
         // bits 7, 3 and 2 are dropped here
         cfg.usbSrc <= susc_usb_src_t'(
                       sfrWrData[`SUSC_USB_MSB:`SUSC_USB_LSB]); // see R1
         cfg.sysSrc <= susc_sys_src_t'(
                       sfrWrData[`SUSC_SYS_MSB:`SUSC_SYS_LSB]); // see R2
      end
   end

   // read path; unused bits and unmapped addresses give zero
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         sfrRdData <= 8'h00;
      end else if (sfrRd && regHit) begin
         sfrRdData <= 8'h00;
         sfrRdData[`SUSC_USB_MSB:`SUSC_USB_LSB] <= cfg.usbSrc;
         sfrRdData[`SUSC_SYS_MSB:`SUSC_SYS_LSB] <= cfg.sysSrc;
         sfrRdData[`SUSC_UNUSED_HI_BIT] <= 1'b0;             // see R5
         sfrRdData[`SUSC_UNUSED_MSB:`SUSC_UNUSED_LSB] <= 2'h0; // see R6
      end else begin
         sfrRdData <= 8'h00;
      end
   end

   // halving dividers run free so a later switch finds them running
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         intPhase <= 1'b0;
         mulPhase <= 1'b0;
      end else begin
         if (intOscTick)
            intPhase <= ~intPhase;
         if (mulTick)
            mulPhase <= ~mulPhase;
      end
   end

   assign intHalfTick = intOscTick && intPhase;
   assign mulHalfTick = mulTick && mulPhase;
   // >= rather than == so a smaller ratio written mid-count still wraps
   assign extDivTick  = extOscTick &&
                        ({1'b0, extCnt} >= ext_divisor(cfg.usbSrc) - 3'h1);

   // external divider for usb, ratio 1 to 4
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         extCnt <= 2'h0;
      end else if (extOscTick) begin
         if (extDivTick)
            extCnt <= 2'h0;
         else
            extCnt <= extCnt + 2'h1;
      end
   end

   // active system source follows the field only when the target is
   // ready; a reserved code or an unsettled source keeps the old one
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         sysSrcActive <= SYS_INT;                               // see R9
      end else if (src_ready(cfg.sysSrc, intOscReady,
                             extOscReady, mulReady)) begin
         sysSrcActive <= cfg.sysSrc;                            // see R8
      end
   end

   // system clock enable from the active source
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         sysClkTick <= 1'b0;
      end else begin
         unique case (sysSrcActive)
            SYS_INT:      sysClkTick <= intOscTick;             // see R2
            SYS_EXT:      sysClkTick <= extOscTick;             // see R2
            SYS_MUL_DIV2: sysClkTick <= mulHalfTick;            // see R2
            SYS_RSVD:     sysClkTick <= 1'b0;
         endcase
      end
   end

   // usb clock enable; reserved codes stop it
   // rate checks (48 or 6 MHz) are left to software
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         usbClkTick <= 1'b0;
      end else begin
         unique case (cfg.usbSrc)
            USB_MUL:      usbClkTick <= mulTick;                // see R1
            USB_INT_DIV2: usbClkTick <= intHalfTick;            // see R1
            USB_EXT:      usbClkTick <= extOscTick;             // see R1
            USB_EXT_DIV2,
            USB_EXT_DIV3,
            USB_EXT_DIV4: usbClkTick <= extDivTick;             // see R1
            USB_RSVD_6,
            USB_RSVD_7:   usbClkTick <= 1'b0;                   // see R1
         endcase
      end
   end

   default clocking dcb @(posedge sys_clk); endclocking
   default disable iff (!rstn);

   a_write_fields: assert property ( // see R1
      (sfrWr && regHit) |=>
         (cfg.usbSrc == $past(sfrWrData[6:4])) &&
         (cfg.sysSrc == $past(sfrWrData[1:0])))
      else $error("written fields not stored");

   a_read_bit7: assert property ( // see R5
      $past(sfrRd && regHit) |->
         !sfrRdData[`SUSC_UNUSED_HI_BIT] &&
         (sfrRdData[`SUSC_USB_MSB:`SUSC_USB_LSB] == $past(cfg.usbSrc)))
      else $error("bit 7 or usb field read back wrong");

   a_read_bits32: assert property ( // see R6
      $past(sfrRd && regHit) |->
         (sfrRdData[`SUSC_UNUSED_MSB:`SUSC_UNUSED_LSB] == 2'h0) &&
         (sfrRdData[`SUSC_SYS_MSB:`SUSC_SYS_LSB] == $past(cfg.sysSrc)))
      else $error("bits 3 and 2 or system field read back wrong");

   // read data stands one cycle only, so a stale byte never lingers
   a_read_idle: assert property ( // see R5
      !$past(sfrRd && regHit) |-> (sfrRdData == 8'h00))
      else $error("read data not zero outside a read");

   a_usb_mul: assert property ( // see R1
      (cfg.usbSrc == USB_MUL) |=> (usbClkTick == $past(mulTick)))
      else $error("usb clock not following multiplier");

   a_usb_ext4: assert property ( // see R1
      (cfg.usbSrc == USB_EXT_DIV4) && extOscTick && (extCnt == 2'h3)
      |=> usbClkTick)
      else $error("usb divide by four missed its pulse");

   a_usb_rsvd: assert property ( // see R1
      (cfg.usbSrc[2:1] == 2'h3) |=> !usbClkTick)
      else $error("reserved usb code produced a clock");

   a_sys_ext: assert property ( // see R2
      (sysSrcActive == SYS_EXT) |=> (sysClkTick == $past(extOscTick)))
      else $error("system clock not following external source");

   a_sys_hold: assert property ( // see R8
      !src_ready(cfg.sysSrc, intOscReady, extOscReady, mulReady)
      |=> $stable(sysSrcActive))
      else $error("switched to an unready system source");

   a_reset_clear: assert property ( // see R9
      !$past(rstn) |-> (cfg == '0) && (sysSrcActive == SYS_INT))
      else $error("register not clear after reset");

endmodule : susc_clock_select

// ===== tb/test_susc_clock_select.sv
`timescale 1ns/1ns
module test_susc_clock_select import susc_pkg::*; ;
   logic          sys_clk = 1'b0;
   logic          rstn = 1'b0;
   logic [7:0]    sfrAddr = 8'h00;
   logic [7:0]    sfrWrData = 8'h00;
   logic          sfrWr = 1'b0;
   logic          sfrRd = 1'b0;
   logic [7:0]    sfrRdData;
   logic          intOscTick = 1'b0;
   logic          extOscTick = 1'b0;
   logic          mulTick = 1'b0;
   logic          intOscReady = 1'b1;
   logic          extOscReady = 1'b1;
   logic          mulReady = 1'b0;
   logic          sysClkTick;
   logic          usbClkTick;
   susc_sys_src_t sysSrcActive;
   int            bad_count = 0;
   int            cmp_count = 0;
   int            cyc = 0;
   int            extPeriod = 3;
   logic [7:0]    d;
   int            s;
   int            u;

   susc_clock_select u_susc_clock_select (.sys_clk(sys_clk), .rstn(rstn),
      .sfrAddr(sfrAddr), .sfrWrData(sfrWrData), .sfrWr(sfrWr),
      .sfrRd(sfrRd), .sfrRdData(sfrRdData), .intOscTick(intOscTick),
      .extOscTick(extOscTick), .mulTick(mulTick),
      .intOscReady(intOscReady), .extOscReady(extOscReady),
      .mulReady(mulReady), .sysClkTick(sysClkTick),
      .usbClkTick(usbClkTick), .sysSrcActive(sysSrcActive));

   // 8 ns period
   always #4 sys_clk = ~sys_clk;

   // sources at distinct rates; system internal and multiplier/2 still give the same count
   always @(posedge sys_clk) begin
      #1;
      cyc = cyc + 1;
      intOscTick = (cyc % 2 == 0);
      extOscTick = (cyc % extPeriod == 0);
      mulTick = 1'b1;
   end

   task automatic chk(input string n, input logic [7:0] e,
                      input logic [7:0] g);
      cmp_count++;
      if (g !== e) begin
         bad_count++;
         $display("[FAIL] %s expected %h seen %h", n, e, g);
      end
   endtask : chk

   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      @(posedge sys_clk); #1;
      sfrAddr = a;
      sfrWrData = v;
      sfrWr = 1'b1;
      @(posedge sys_clk); #1;
      sfrWr = 1'b0;
   endtask : wr

   task automatic rd(input logic [7:0] a, output logic [7:0] v);
      @(posedge sys_clk); #1;
      sfrAddr = a;
      sfrRd = 1'b1;
      @(posedge sys_clk); #1;
      sfrRd = 1'b0;
      v = sfrRdData;
   endtask : rd

   // window of 144 cycles is a whole number of every divided period
   task automatic tally(output int ns, output int nu);
      ns = 0;
      nu = 0;
      repeat (16) @(posedge sys_clk);
      repeat (144) begin
         @(posedge sys_clk); #1;
         if (sysClkTick === 1'b1) ns++;
         if (usbClkTick === 1'b1) nu++;
      end
   endtask : tally

   task automatic t_reset();
      rd(8'hA9, d);
      chk("reset value", 8'h00, d);
      chk("reset sys source", 8'(SYS_INT), 8'(sysSrcActive));
   endtask : t_reset

   // unstored bits, reserved system code and unmapped address
   task automatic t_bits();
      wr(8'hA9, 8'hFF);
      rd(8'hA9, d);
      chk("unused bits", 8'h73, d);
      chk("reserved sys code", 8'(SYS_INT), 8'(sysSrcActive));
      wr(8'hAA, 8'h5A);
      rd(8'hA9, d);
      chk("foreign write", 8'h73, d);
      rd(8'hAA, d);
      chk("unmapped read", 8'h00, d);
      wr(8'hA9, 8'h80);
      rd(8'hA9, d);
      chk("bit7 only", 8'h00, d);
   endtask : t_bits

   // switching waits for the new source to be ready
   task automatic t_sys();
      extOscReady = 1'b0;
      wr(8'hA9, 8'h01);
      repeat (4) @(posedge sys_clk);
      #1;
      chk("unready ext", 8'(SYS_INT), 8'(sysSrcActive));
      extOscReady = 1'b1;
      tally(s, u);
      chk("sys ext", 8'(SYS_EXT), 8'(sysSrcActive));
      chk("sys ext ticks", 8'h30, 8'(s));
      wr(8'hA9, 8'h02);
      repeat (4) @(posedge sys_clk);
      #1;
      chk("unready mul", 8'(SYS_EXT), 8'(sysSrcActive));
      mulReady = 1'b1;
      tally(s, u);
      chk("sys mul", 8'(SYS_MUL_DIV2), 8'(sysSrcActive));
      chk("sys mul ticks", 8'h48, 8'(s));
      wr(8'hA9, 8'h00);
      tally(s, u);
      chk("sys int", 8'(SYS_INT), 8'(sysSrcActive));
      chk("sys int ticks", 8'h48, 8'(s));
   endtask : t_sys

   // every usb code, reserved ones included
   task automatic t_usb();
      int exp [8] = '{144, 36, 48, 24, 16, 12, 0, 0};
      for (int c = 0; c < 8; c++) begin
         wr(8'hA9, {1'b0, 3'(c), 4'h1});
         tally(s, u);
         chk("usb ticks", 8'(exp[c]), 8'(u));
      end
   endtask : t_usb

   // scaled rates: a tick every cycle stands for 48 MHz, a tick every
   // second cycle for the 24 MHz crystal
   task automatic t_speed();
      wr(8'hA9, 8'h00);
      tally(s, u);
      chk("full speed usb", 8'h90, 8'(u));
      wr(8'hA9, 8'h10);
      tally(s, u);
      chk("internal over two", 8'h24, 8'(u));
      extPeriod = 2;
      wr(8'hA9, 8'h50);
      tally(s, u);
      chk("low speed usb", 8'h12, 8'(u));
      extPeriod = 3;
   endtask : t_speed

   // reset in mid-run must clear a non-zero register
   task automatic t_rerst();
      wr(8'hA9, 8'h52);
      repeat (2) @(posedge sys_clk);
      #1;
      chk("before reset", 8'(SYS_MUL_DIV2), 8'(sysSrcActive));
      rstn = 1'b0;
      repeat (2) @(posedge sys_clk);
      #1;
      rstn = 1'b1;
      rd(8'hA9, d);
      chk("mid-run reset value", 8'h00, d);
      chk("mid-run sys source", 8'(SYS_INT), 8'(sysSrcActive));
   endtask : t_rerst

   task automatic wrap_up();
      $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : wrap_up

   // run needs about 2300 cycles; 12500 leaves ample margin
   initial begin
      #100000;
      bad_count++;
      wrap_up();
   end

   initial begin
      repeat (20) @(posedge sys_clk);
      #1;
      rstn = 1'b1;
      t_reset();
      t_bits();
      t_sys();
      t_usb();
      t_speed();
      t_rerst();
      wrap_up();
   end
endmodule : test_susc_clock_select
